//--- core/ist_pkg.sv
package ist_pkg;

    // ------------------------------------------------------------
    // counts and reset values
    // ------------------------------------------------------------
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_ADDR_LAST = 4'h8;
    localparam logic [3:0] CNT_TX_LAST = 4'h7;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic FLAG_RESET = 1'b0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK_ADDR,
        ST_HOLD,
        ST_TX,
        ST_TX_ACK
    } ist_state_type;

    typedef struct packed {
        logic rw;
        logic buffer_full_flag;
        logic receive_overflow_flag;
        logic serial_port_interrupt_flag;
        logic clock_release_bit;
    } ist_status_type;

    typedef struct packed {
        logic buf_wr;
        logic buf_rd;
        logic release_clk;
        logic ovf_clr;
        logic irq_clr;
    } ist_cmd_type;

endpackage

//--- core/ist_slave_tx.sv
`timescale 1ns/1ps

// Notes on behaviour
// [R01] matched address with read direction sets the read/write status flag
// [R02] matched address byte is copied into the serial buffer when acknowledged
// [R03] acknowledge on ninth clock, then hold scl low when the read direction is flagged
// [R04] software buffer write also loads the shift register
// [R05] scl stays held low until software sets the clock release bit
// [R06] master watches scl before each new pulse, waiting while stretched
// [R07] eight data bits change on falling scl, stable while scl high
// [R08] upper seven shifted bits compared with address on eighth falling edge
// [R09] acknowledged match sets buffer full, interrupt flag set on ninth falling edge
// [R10] buffer full or overflow already set: no acknowledge, buffer untouched
// [R11] buffer read clears buffer full; overflow cleared only by software
// [R12] sda released during ninth clock after data so master can acknowledge
module ist_slave_tx
    import ist_pkg::*;
#(
    parameter int DEPTH = 2
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // i2c pins
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // software side
    input wire ist_cmd_type cmd,
    input wire logic [7:0] wdata,
    input wire logic [6:0] slave_address_register,
    output ist_status_type serial_port_status,
    output logic [7:0] serial_buffer,
    // received address stream
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready
);

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
            $error("DEPTH must be a power of two, at least 2");
        end
    endgenerate

    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    // ------------------------------------------------------------
    // pin synchronisers and edges
    // ------------------------------------------------------------
    logic scl_s1_q, scl_s2_q, scl_s3_q;
    logic sda_s1_q, sda_s2_q, sda_s3_q;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            {scl_s1_q, scl_s2_q, scl_s3_q} <= 3'h7;
            {sda_s1_q, sda_s2_q, sda_s3_q} <= 3'h7;
        end else begin
            {scl_s1_q, scl_s2_q, scl_s3_q} <= {scl_i, scl_s1_q, scl_s2_q};
            {sda_s1_q, sda_s2_q, sda_s3_q} <= {sda_i, sda_s1_q, sda_s2_q};
        end
    end

    wire scl_rise = scl_s2_q & ~scl_s3_q;
    wire scl_fall = ~scl_s2_q & scl_s3_q;
    wire start_det = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
    wire stop_det = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;

    // ------------------------------------------------------------
    // state and decode
    // ------------------------------------------------------------
    ist_state_type st_q, st_d;
    logic [3:0] cnt_q;
    logic [7:0] shift_q, buf_q;
    logic ack_q, mnack_q, rw_q, full_q, ovf_q, irq_q, rel_q;
    logic fifo_in_ready;

    wire addr_done = (st_q == ST_ADDR) & scl_fall & (cnt_q == CNT_ADDR_LAST);
    wire addr_match = shift_q[7:1] == slave_address_register; // R08
    wire rx_ok = ~full_q & ~ovf_q & fifo_in_ready; // R10
    wire take = addr_done & addr_match & rx_ok;
    wire enter_hold = (st_d == ST_HOLD) & (st_q != ST_HOLD);
    wire enter_tx = (st_d == ST_TX) & (st_q != ST_TX);
    wire ninth_fall = scl_fall & ((st_q == ST_ACK_ADDR) | (st_q == ST_TX_ACK));

    always_comb begin
        st_d = st_q;
        if (start_det) begin
            st_d = ST_ADDR;
        end else if (stop_det) begin
            st_d = ST_IDLE;
        end else begin
            unique case (st_q)
                ST_IDLE: st_d = ST_IDLE;
                ST_ADDR: begin
                    if (addr_done) begin
                        st_d = addr_match ? ST_ACK_ADDR : ST_IDLE; // R08
                    end
                end
                ST_ACK_ADDR: begin
                    if (scl_fall) begin
                        st_d = (ack_q & rw_q) ? ST_HOLD : ST_IDLE; // R03
                    end
                end
                ST_HOLD: begin
                    if (rel_q) begin
                        st_d = ST_TX; // R05
                    end
                end
                ST_TX: begin
                    if (scl_fall && cnt_q == CNT_TX_LAST) begin
                        st_d = ST_TX_ACK;
                    end
                end
                ST_TX_ACK: begin
                    if (scl_fall) begin
                        st_d = mnack_q ? ST_IDLE : ST_HOLD;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_q <= ST_IDLE;
            cnt_q <= CNT_ZERO;
        end else begin
            st_q <= st_d;
            if (start_det || enter_tx) begin
                cnt_q <= CNT_ZERO;
            end else if ((st_q == ST_ADDR && scl_rise) ||
                         (st_q == ST_TX && scl_fall)) begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // shift register and buffer
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            shift_q <= BYTE_RESET;
        end else if (cmd.buf_wr) begin
            shift_q <= wdata; // R04
        end else if (st_q == ST_ADDR && scl_rise) begin
            shift_q <= {shift_q[6:0], sda_s2_q};
        end else if (st_q == ST_TX && scl_fall) begin
            shift_q <= {shift_q[6:0], 1'b0}; // R07
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            buf_q <= BYTE_RESET;
        end else if (cmd.buf_wr) begin
            buf_q <= wdata;
        end else if (take) begin
            buf_q <= shift_q; // R02
        end
    end

    // ------------------------------------------------------------
    // flags
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ack_q <= FLAG_RESET;
            mnack_q <= FLAG_RESET;
            rw_q <= FLAG_RESET;
        end else begin
            if (addr_done) begin
                ack_q <= take; // R10
            end
            if (addr_done && addr_match) begin
                rw_q <= shift_q[0]; // R01
            end
            if (st_q == ST_TX_ACK && scl_rise) begin
                mnack_q <= sda_s2_q;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            full_q <= FLAG_RESET;
            ovf_q <= FLAG_RESET;
            irq_q <= FLAG_RESET;
            rel_q <= FLAG_RESET;
        end else begin
            full_q <= take | (full_q & ~cmd.buf_rd); // R09 R11
            ovf_q <= (addr_done & addr_match & full_q) |
                     (ovf_q & ~cmd.ovf_clr); // R11
            irq_q <= ninth_fall | (irq_q & ~cmd.irq_clr); // R09
            rel_q <= cmd.release_clk | (rel_q & ~enter_hold); // R05
        end
    end

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    wire drive_data = (st_q == ST_HOLD) | (st_q == ST_TX);
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe = st_q == ST_HOLD; // R03 R05
    assign sda_oe = ((st_q == ST_ACK_ADDR) & ack_q) | // R03
                    (drive_data & ~shift_q[7]); // R07 R12

    assign serial_port_status = '{rw: rw_q, buffer_full_flag: full_q,
        receive_overflow_flag: ovf_q, serial_port_interrupt_flag: irq_q,
        clock_release_bit: rel_q};
    assign serial_buffer = buf_q;

    // ------------------------------------------------------------
    // DEPTH-entry buffer for matched address bytes
    // ------------------------------------------------------------
    logic [7:0] mem_q [DEPTH];
    logic [PW-1:0] wr_ptr_q, rd_ptr_q;
    logic [CW-1:0] count_q;
    wire pop = rx_valid & rx_ready;

    assign fifo_in_ready = count_q != CW'(DEPTH);
    assign rx_valid = count_q != '0;
    assign rx_data = mem_q[rd_ptr_q];

    always_ff @(posedge mclk) begin
        if (take) begin
            mem_q[wr_ptr_q] <= shift_q;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            wr_ptr_q <= wr_ptr_q + PW'(take);
            rd_ptr_q <= rd_ptr_q + PW'(pop);
            count_q <= count_q + CW'(take) - CW'(pop);
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_addr_match;
        addr_done && addr_match;
    endsequence

    sequence s_ninth_hold;
        st_q == ST_ACK_ADDR && ack_q && rw_q && scl_fall && !start_det
            && !stop_det;
    endsequence

    a_rw_flag_set: assert property ( // R01
        s_addr_match ##0 shift_q[0] |=> serial_port_status.rw)
        else $error("read direction not flagged");
    a_buffer_load: assert property ( // R02
        s_addr_match ##0 rx_ok && !cmd.buf_wr |=>
            serial_buffer == $past(shift_q))
        else $error("address byte not buffered");
    a_ack_then_hold: assert property ( // R03
        s_ninth_hold |=> scl_oe && !scl_o)
        else $error("scl not held after ack");
    a_sw_load_shift: assert property ( // R04
        cmd.buf_wr |=> shift_q == $past(wdata))
        else $error("shift register not loaded");
    a_release_wait: assert property ( // R05
        st_q == ST_HOLD && !rel_q && !start_det && !stop_det |=>
            st_q == ST_HOLD && scl_oe)
        else $error("scl released early");
    a_sda_stable: assert property ( // R07
        st_q == ST_TX && !scl_fall && !cmd.buf_wr && !start_det &&
            !stop_det |=> $stable(sda_oe))
        else $error("sda changed off falling edge");
    a_addr_miss: assert property ( // R08
        addr_done && !addr_match && !start_det && !stop_det |=>
            st_q == ST_IDLE && !full_q == !$past(full_q))
        else $error("mismatch not dropped");
    a_ninth_irq: assert property ( // R09
        ninth_fall |=> serial_port_status.serial_port_interrupt_flag)
        else $error("interrupt flag missed");
    a_full_nack: assert property ( // R10
        s_addr_match ##0 (full_q || ovf_q) && !cmd.buf_wr |=>
            !ack_q && $stable(buf_q) ##1 !sda_oe)
        else $error("acked while full");
    a_read_clears: assert property ( // R11
        cmd.buf_rd && !take |=> !full_q)
        else $error("buffer full not cleared");
    a_ack_slot_free: assert property ( // R12
        st_q == ST_TX_ACK |-> !sda_oe)
        else $error("sda driven in ack slot");

endmodule // ist_slave_tx

//--- test/ist_master.sv
`timescale 1ns/1ps

module ist_master (
    // clock and bus wires
    input wire logic mclk,
    input wire logic scl_w,
    input wire logic sda_w,
    // open-drain pulls
    output logic scl_low,
    output logic sda_low
);
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end

    task automatic hw(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic start_c();
        hw(6);
        sda_low = 1'b1;
        hw(6);
        scl_low = 1'b1;
    endtask

    task automatic stop_c();
        hw(2);
        sda_low = 1'b1;
        hw(4);
        scl_low = 1'b0;
        hw(6);
        sda_low = 1'b0;
        hw(6);
    endtask

    // one bit, sampled twice while high to catch a moving sda
    task automatic bit_c(input logic b, output logic r);
        logic s0;
        hw(2);
        sda_low = ~b;
        hw(4);
        scl_low = 1'b0;
        do @(negedge mclk); while (!scl_w);
        s0 = sda_w;
        hw(5);
        r = (s0 === sda_w) ? s0 : 1'bx;
        scl_low = 1'b1;
    endtask

    task automatic byte_c(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            bit_c(tx[i], rx[i]);
        end
    endtask
endmodule // ist_master

//--- test/test_ist_slave_tx.sv
`timescale 1ns/1ps

module test_ist_slave_tx;
    import ist_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic mclk, rst, scl_o, scl_oe, sda_o, sda_oe, rx_valid, rx_ready;
    ist_cmd_type cmd;
    ist_status_type st;
    logic [7:0] wdata, serial_buffer, rx_data, ebuf, got, d;
    logic [6:0] slave_address_register, a;
    logic scl_low, sda_low, ack, nak, ebf, eovf, acc, bad;
    logic [7:0] rxq[$];
    int failures = 0;
    int check_count = 0;
    int seed = 44284;
    wire scl_w = ~(scl_low | scl_oe);
    wire sda_w = ~(sda_low | sda_oe);

    ist_slave_tx #(.DEPTH(2)) dut (.mclk(mclk), .rst(rst), .scl_i(scl_w),
        .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe(sda_oe), .cmd(cmd), .wdata(wdata),
        .slave_address_register(slave_address_register),
        .serial_port_status(st), .serial_buffer(serial_buffer),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready));
    ist_master m (.mclk(mclk), .scl_w(scl_w), .sda_w(sda_w),
        .scl_low(scl_low), .sda_low(sda_low));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic sw(input logic [4:0] c, input logic [7:0] v);
        @(negedge mclk);
        cmd = ist_cmd_type'(c);
        wdata = v;
        @(negedge mclk);
        cmd = ist_cmd_type'(5'h00);
    endtask

    task automatic print_verdict();
        if (failures == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // clock, watchdog, sequence
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        #500000;
        failures++;
        print_verdict();
    end

    initial begin
        rst = 1'b1;
        cmd = ist_cmd_type'(5'h00);
        wdata = 8'h00;
        slave_address_register = 7'h00;
        rx_ready = 1'b0;
        ebf = 1'b0;
        eovf = 1'b0;
        ebuf = 8'h00;
        repeat (3) @(negedge mclk);
        rst = 1'b0;
        for (int k = 0; k < 6; k++) begin
            a = 7'($random(seed));
            d = 8'($random(seed));
            bad = (k == 4);
            slave_address_register = a;
            m.start_c();
            m.byte_c({a ^ {6'h00, bad}, 1'b1}, got);
            m.bit_c(1'b1, ack);
            acc = !bad && !ebf && !eovf && rxq.size() < 2;
            repeat (4) @(negedge mclk);
            if (acc) begin
                ebuf = {a, 1'b1};
                ebf = 1'b1;
                rxq.push_back(ebuf);
            end else if (!bad && ebf) begin
                eovf = 1'b1;
            end
            chk("ack", ack, !acc);
            chk("buffer", serial_buffer, ebuf);
            chk("full", st.buffer_full_flag, ebf);
            chk("overflow", st.receive_overflow_flag, eovf);
            if (acc) begin
                chk("rw", st.rw, 1'b1);
                chk("irq", st.serial_port_interrupt_flag, 1'b1);
                fork
                    m.byte_c(8'hff, got);
                    begin
                        repeat (30) @(negedge mclk);
                        chk("stretch", scl_oe, 1'b1);
                        sw(5'h10, d);
                        ebuf = d;
                        sw(5'h04, 8'h00);
                    end
                join
                m.bit_c(1'b1, nak);
                chk("data", got, d);
                chk("sda_free", nak, 1'b1);
                chk("pins_low", {6'h00, scl_o, sda_o}, 8'h00);
            end
            m.stop_c();
            sw({1'b0, k != 1, 1'b0, eovf, 1'b1}, 8'h00);
            if (k != 1) ebf = 1'b0;
            eovf = 1'b0;
            if (k == 3) begin
                while (rxq.size() > 0) begin
                    chk("rx_valid", rx_valid, 1'b1);
                    chk("rx_data", rx_data, rxq.pop_front());
                    @(negedge mclk);
                    rx_ready = 1'b1;
                    @(negedge mclk);
                    rx_ready = 1'b0;
                end
                chk("rx_empty", rx_valid, 1'b0);
            end
        end
        print_verdict();
    end
endmodule // test_ist_slave_tx
